// File: dv/boundary_scan_cell_chain_test.sv
// Self-checking bench for the boundary-scan cell chain.
`timescale 1ns/1ps
module boundary_scan_cell_chain_test;
  import bsc_pkg::*;
  typedef struct packed {bsc_tap_ctrl_t mode; logic [53:0] upd; logic [7:0] oe; logic [3:0] out;} bsc_row_t;
  localparam bsc_row_t ROWS [4] = '{{7'h08, 54'h12, 8'h44, 4'h8}, {7'h08, 54'h86001000, 8'h2c, 4'h6},
    {7'h02, 54'h300004000, 8'h16, 4'h1}, {7'h02, 54'h100800000001, 8'h04, 4'h0}};
  logic clk, sys_rst, tck, tdi, tdo;
  bsc_tap_ctrl_t tap_ctrl;
  logic [53:0] pad_in, core_out, core_oe, pad_out, pad_oe, dout, prev;
  int fail_count, cmp_count;
  bsc_chain dut_u (.clk(clk), .sys_rst(sys_rst), .tck(tck), .tdi(tdi), .tap_ctrl(tap_ctrl), .pad_in(pad_in),
    .core_out(core_out), .core_oe(core_oe), .tdo(tdo), .pad_out(pad_out), .pad_oe(pad_oe));
  bsc_tester u_tester (.tdo(tdo), .tck(tck), .tdi(tdi), .tap_ctrl(tap_ctrl));
  task automatic cmp(input logic [53:0] got, input logic [53:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic end_of_test;
    $display("mismatches %0d compares %0d", fail_count, cmp_count);
    if (fail_count == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // A hung run counts as a mismatch.
  initial begin
    #300000 fail_count++;
    end_of_test();
  end
  // Normal mode, capture, one loop of update rows, then highz and reset.
  initial begin
    sys_rst = 1'b1;
    pad_in = '0;
    core_out = '0;
    core_oe = '0;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    core_out <= 54'h2;
    core_oe <= 54'h800;
    pad_in <= 54'h3fdfffffffffff;
    repeat (6) @(posedge clk);
    #3 cmp({pad_out[1], pad_oe[11]}, 2'h3);
    u_tester.scan(7'h04, '0, dout);
    cmp({dout[47:44], dout[38], dout[34], dout[0]}, 7'h6f);
    cmp({dout[53], dout[37:35]}, 4'h0);
    prev = '0;
    foreach (ROWS[k]) begin
      @(posedge clk);
      #3 u_tester.scan(ROWS[k].mode, ROWS[k].upd, dout);
      cmp({pad_oe[0], pad_oe[1], pad_oe[11], pad_oe[13], pad_oe[25], pad_oe[31], pad_oe[32], pad_oe[44]}, ROWS[k].oe);
      cmp({pad_out[1], pad_out[25], pad_out[31], pad_out[32]}, ROWS[k].out);
      if (ROWS[k].mode.clamp) cmp(dout, prev);
      if (ROWS[k].mode.external_test_instruction) cmp({dout[31], dout[12], dout[4]}, 3'h0);
      prev = ROWS[k].upd;
    end
    u_tester.set_mode(7'h01);
    repeat (8) @(posedge clk);
    #3 cmp(pad_oe, '0);
    u_tester.set_mode(7'h08);
    repeat (8) @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    #3 cmp(pad_oe | pad_out, '0);
    @(posedge clk);
    sys_rst <= 1'b0;
    repeat (8) @(posedge clk);
    #3 cmp(pad_oe | pad_out, 54'h80000000);
    end_of_test();
  end
endmodule : boundary_scan_cell_chain_test
bind bsc_chain bsc_chain_asserts #(.CELLS(CELLS)) u_chk (.clk(clk), .sys_rst(sys_rst), .tck(tck), .tap_ctrl(tap_ctrl),
  .core_out(core_out), .core_oe(core_oe), .tdo(tdo), .pad_out(pad_out), .pad_oe(pad_oe));

// File: dv/bsc_chain_asserts.sv
// Concurrent checks on the pins of the boundary-scan chain.
`timescale 1ns/1ps
module bsc_chain_asserts
  import bsc_pkg::*;
#(
  parameter int unsigned CELLS = BSC_CELLS
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic tck,
  input wire bsc_tap_ctrl_t tap_ctrl,
  input wire logic [CELLS-1:0] core_out,
  input wire logic [CELLS-1:0] core_oe,
  input wire logic tdo,
  input wire logic [CELLS-1:0] pad_out,
  input wire logic [CELLS-1:0] pad_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // A mode counts only once it has had time to cross the synchroniser.
  sequence s_test;
    (tap_ctrl.external_test_instruction && !tap_ctrl.highz)[*6];
  endsequence
  sequence s_norm;
    !(tap_ctrl.external_test_instruction || tap_ctrl.clamp || tap_ctrl.highz)[*6];
  endsequence
  a_input_no_drive:
    assert property (s_test |-> !pad_oe[0] && !pad_oe[34] && !pad_oe[38] && !pad_oe[47:44]) else $error("input driven");
  a_internal_quiet:
    assert property (s_test |-> !pad_oe[37:35] && !pad_oe[53]) else $error("internal driven");
  a_control_quiet:
    assert property (s_test |-> !pad_oe[4] && !pad_oe[12] && !pad_oe[26] && !pad_oe[33]) else $error("control driven");
  a_shared_enable:
    assert property (s_test |-> pad_oe[1] == pad_oe[52] && pad_oe[9] == pad_oe[43]) else $error("shared enable split");
  a_clock_driven:
    assert property (s_test |-> pad_oe[31]) else $error("clock pin released");
  a_highz_quiet:
    assert property (tap_ctrl.highz[*6] |-> pad_oe == '0) else $error("pin driven in highz");
  a_core_follow:
    assert property (s_norm |-> pad_oe[11] == $past(core_oe[11]) && pad_out[1] == $past(core_out[1]))
      else $error("pin not from core");
  a_tdo_on_fall:
    assert property ($changed(tdo) |-> !$past(tck, 2)) else $error("tdo moved off a fall");
endmodule : bsc_chain_asserts

// File: dv/bsc_tester.sv
// Model of the external tester on the test access port.
`timescale 1ns/1ps
module bsc_tester
  import bsc_pkg::*;
(
  input wire logic tdo,
  output logic tck,
  output logic tdi,
  output bsc_tap_ctrl_t tap_ctrl
);
  initial begin
    tck = 1'b0;
    tdi = 1'b0;
    tap_ctrl = '0;
  end
  task automatic set_mode(input bsc_tap_ctrl_t mode);
    tap_ctrl = mode;
  endtask : set_mode
  // Capture, 54 shifts, then update; controls move mid-high so each stays put from fall to rise.
  task automatic scan(input bsc_tap_ctrl_t mode, input logic [53:0] din, output logic [53:0] dout);
    bsc_tap_ctrl_t next_ctrl;
    logic next_tdi;
    next_ctrl = mode;
    next_ctrl.capture = 1'b1;
    tap_ctrl = next_ctrl;
    for (int i = 0; i < 56; i++) begin
      #75 if (i > 0 && i < 55) dout[i-1] = tdo;
      #5 tck = 1'b1;
      #40 next_ctrl = mode;
      next_tdi = ~tdi; // Idle data toggles so a stale bit cannot pass.
      if (i < 54) begin
        next_ctrl.shift = 1'b1;
        next_tdi = din[i];
      end
      next_ctrl.update = (i == 54);
      // Each pin is written once per step so the chain never sees a glitch.
      tap_ctrl = next_ctrl;
      tdi = next_tdi;
      #40 tck = 1'b0;
    end
  endtask : scan
endmodule : bsc_tester

// File: rtl/bsc_chain.sv
// Boundary-scan cell chain of 54 cells with capture, shift, update and pin muxing.
`timescale 1ns/1ps
module bsc_chain
  import bsc_pkg::*;
#(
  parameter int unsigned CELLS = BSC_CELLS
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic tck,
  input wire logic tdi,
  input wire bsc_tap_ctrl_t tap_ctrl,
  input wire logic [CELLS-1:0] pad_in,
  input wire logic [CELLS-1:0] core_out,
  input wire logic [CELLS-1:0] core_oe,
  output logic tdo,
  output logic [CELLS-1:0] pad_out,
  output logic [CELLS-1:0] pad_oe
);

  bsc_link_t link_raw;
  bsc_link_t link_s;
  logic [CELLS-1:0] pad_s;
  logic tck_prev;
  logic next_tck_prev;
  logic tck_rise;
  logic tck_fall;
  logic [CELLS-1:0] shift_reg;
  logic [CELLS-1:0] next_shift_reg;
  logic [CELLS-1:0] upd_reg;
  logic [CELLS-1:0] next_upd_reg;
  logic next_tdo;
  logic [CELLS-1:0] next_pad_out;
  logic [CELLS-1:0] next_pad_oe;
  logic test_drive;

  assign link_raw = '{tck: tck, tdi: tdi, ctrl: tap_ctrl};

  // Test clock and TAP levels come from another domain and are synchronised as one group.
  bsc_sync #(.WIDTH($bits(bsc_link_t))) u_link_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .async_in(link_raw),
    .sync_out(link_s)
  );

  // Pad levels are synchronised before the capture path samples them.
  bsc_sync #(.WIDTH(CELLS)) u_pad_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .async_in(pad_in),
    .sync_out(pad_s)
  );

  // Test clock edges are found on the synchronised copy, never on the first stage.
  assign tck_rise = link_s.tck && !tck_prev;
  assign tck_fall = !link_s.tck && tck_prev;
  assign test_drive = link_s.ctrl.external_test_instruction || link_s.ctrl.clamp;

  // Capture and shift act on the test clock rise; update and TDO move on its fall.
  always_comb begin
    next_tck_prev = link_s.tck;
    next_shift_reg = shift_reg;
    next_upd_reg = upd_reg;
    next_tdo = tdo;
    if (tck_rise && link_s.ctrl.capture && (link_s.ctrl.sample || link_s.ctrl.external_test_instruction)) begin
      for (int i = 0; i < CELLS; i++) begin
        case (bsc_kind(6'(i)))
          BSC_INPUT, BSC_BIDIR: next_shift_reg[i] = pad_s[i];
          BSC_OUTPUT2: next_shift_reg[i] = core_out[i];
          BSC_CONTROL: next_shift_reg[i] = core_oe[i];
          default: next_shift_reg[i] = 1'b0;
        endcase
      end
    end else if (tck_rise && link_s.ctrl.shift) begin
      next_shift_reg = {link_s.tdi, shift_reg[CELLS-1:1]};
    end
    if (tck_fall && link_s.ctrl.update) begin
      next_upd_reg = shift_reg;
    end
    if (tck_fall) begin
      next_tdo = shift_reg[0];
    end
  end

  // Pad drivers follow the core in mission mode and the update stage under test.
  always_comb begin
    next_pad_out = '0;
    next_pad_oe = '0;
    for (int i = 0; i < CELLS; i++) begin
      case (bsc_kind(6'(i)))
        BSC_BIDIR: begin
          next_pad_out[i] = test_drive ? upd_reg[i] : core_out[i];
          next_pad_oe[i] = test_drive ? upd_reg[bsc_ctl_of(6'(i))] : core_oe[i];
        end
        BSC_OUTPUT2: begin
          next_pad_out[i] = test_drive ? upd_reg[i] : core_out[i];
          next_pad_oe[i] = 1'b1;
        end
        default: begin
          next_pad_out[i] = 1'b0;
          next_pad_oe[i] = 1'b0;
        end
      endcase
    end
    // High impedance releases every pad, even the two-state output.
    if (link_s.ctrl.highz) begin
      next_pad_oe = '0;
    end
  end

  // Chain registers; the edge detector resets to the idle low level so no false rise follows reset.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tck_prev <= 1'b0;
      shift_reg <= '0;
      upd_reg <= '0;
      tdo <= 1'b0;
    end else begin
      tck_prev <= next_tck_prev;
      shift_reg <= next_shift_reg;
      upd_reg <= next_upd_reg;
      tdo <= next_tdo;
    end
  end

  // Pad registers; reset releases every pad so nothing on the board is fought.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pad_out <= '0;
      pad_oe <= '0;
    end else begin
      pad_out <= next_pad_out;
      pad_oe <= next_pad_oe;
    end
  end

endmodule : bsc_chain

// File: rtl/bsc_pkg.sv
// Package of constants, types and cell map for the boundary-scan cell chain.
// Functional notes
// - Chain has 54 cells, 0 to 53; cells 35-37 and 53 are internal.
// - Control cell 4 enables most bidirectional pins of the device.
// - Each of eight GPIO pins at 11..25 has its control cell right after.
// - Serial-memory data is bidirectional cell 32, controlled by cell 33.
// - Serial-memory clock is two-state output cell 31 without a control cell.
// - Fundamental reset at cell 34, main-power detect at 38, both input only.
// - Cell 0 is an input test pin; cells 41 to 52 hold the listed pins.
// - Data shifts in from test data input and out at test data output.
// - Sample and external test capture pins in parallel on test clock rise.
package bsc_pkg;

  localparam int unsigned BSC_CELLS = 54;
  localparam int unsigned BSC_IDX_W = 6;
  localparam logic [5:0] BSC_CTL_SHARED = 6'h04;
  localparam logic [5:0] BSC_GPIO_FIRST = 6'h0b;
  localparam logic [5:0] BSC_GPIO_LAST = 6'h19;
  localparam logic [5:0] BSC_MEM_CLK = 6'h1f;
  localparam logic [5:0] BSC_MEM_DATA = 6'h20;
  localparam logic [5:0] BSC_MEM_CTL = 6'h21;
  localparam logic [5:0] BSC_FUND_RST = 6'h22;
  localparam logic [5:0] BSC_INT_FIRST = 6'h23;
  localparam logic [5:0] BSC_INT_LAST = 6'h25;
  localparam logic [5:0] BSC_MAIN_DET = 6'h26;
  localparam logic [5:0] BSC_OVERCUR_FIRST = 6'h2c;
  localparam logic [5:0] BSC_OVERCUR_LAST = 6'h2f;
  localparam logic [5:0] BSC_LAST_CELL = 6'h35;
  localparam logic [5:0] BSC_TEST_IN = 6'h00;
  localparam int unsigned BSC_SYNC_STAGES = 2;

  // Kinds of cell in the chain.
  typedef enum logic [2:0] {
    BSC_INPUT,
    BSC_BIDIR,
    BSC_CONTROL,
    BSC_OUTPUT2,
    BSC_INTERNAL
  } bsc_kind_t;

  // Test-access-port controls as the TAP controller presents them.
  typedef struct packed {
    logic capture;
    logic shift;
    logic update;
    logic external_test_instruction;
    logic sample;
    logic clamp;
    logic highz;
  } bsc_tap_ctrl_t;

  // Link-side signals that must be synchronised together.
  typedef struct packed {
    logic tck;
    logic tdi;
    bsc_tap_ctrl_t ctrl;
  } bsc_link_t;

  // Kind of cell at a chain position.
  function automatic bsc_kind_t bsc_kind(input logic [5:0] idx);
    if (idx == BSC_TEST_IN || idx == BSC_FUND_RST || idx == BSC_MAIN_DET) begin
      return BSC_INPUT;
    end else if (idx >= BSC_OVERCUR_FIRST && idx <= BSC_OVERCUR_LAST) begin
      return BSC_INPUT;
    end else if ((idx >= BSC_INT_FIRST && idx <= BSC_INT_LAST) || idx == BSC_LAST_CELL) begin
      return BSC_INTERNAL;
    end else if (idx == BSC_MEM_CLK) begin
      return BSC_OUTPUT2;
    end else if (idx == BSC_CTL_SHARED || idx == BSC_MEM_CTL) begin
      return BSC_CONTROL;
    end else if (idx > BSC_GPIO_FIRST && idx <= BSC_GPIO_LAST + 6'h01 && !idx[0]) begin
      return BSC_CONTROL;
    end else begin
      return BSC_BIDIR;
    end
  endfunction : bsc_kind

  // Control cell that governs a bidirectional cell.
  function automatic logic [5:0] bsc_ctl_of(input logic [5:0] idx);
    if (idx >= BSC_GPIO_FIRST && idx <= BSC_GPIO_LAST) begin
      return idx + 6'h01;
    end else if (idx == BSC_MEM_DATA) begin
      return BSC_MEM_CTL;
    end else begin
      return BSC_CTL_SHARED;
    end
  endfunction : bsc_ctl_of

endpackage : bsc_pkg

// File: rtl/bsc_sync.sv
// Two-flop synchroniser for a vector of asynchronous levels.
`timescale 1ns/1ps
module bsc_sync
  import bsc_pkg::*;
#(
  parameter int unsigned WIDTH = 1
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_sync_out;

  // The first stage feeds only the second stage.
  always_comb begin
    next_meta = async_in;
    next_sync_out = meta;
  end

  // Register both stages; reset clears them so no stale level leaks out.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= next_meta;
      sync_out <= next_sync_out;
    end
  end

endmodule : bsc_sync
